// File: sim/readout_chk.sv
// checker: wire timing and byte framing of the readout link
// assumes it sees the interface signals of both ends in one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"

module readout_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int LOW_FAST = 2 * `QTR_FAST_CYC;
  localparam int LOW_STD = 2 * `QTR_STD_CYC;
  logic scl_q, sda_q, frame_q, frame_d, rise, start_ev, stop_ev, samp;
  logic [3:0] bit_q, bit_d;
  logic [2:0] byte_q, byte_d;
  logic [7:0] low_q, low_d, free_q, free_d;

  // frame decoder: bit and byte position of each scl rise since start
  always_comb begin
    rise = scl && !scl_q;
    start_ev = scl && scl_q && sda_q && !sda;
    stop_ev = scl && scl_q && !sda_q && sda;
    samp = frame_q && rise;
    frame_d = start_ev ? 1'b1 : (stop_ev ? 1'b0 : frame_q);
    low_d = scl ? 8'h00 : ((low_q == 8'hff) ? low_q : low_q + 8'h01);
    free_d = !(scl && sda) ? 8'h00 : ((free_q == 8'hff) ? free_q : free_q + 8'h01);
    bit_d = bit_q;
    byte_d = byte_q;
    if (start_ev) begin
      bit_d = 4'h0;
      byte_d = 3'h0;
    end else if (samp && bit_q == 4'h8) begin
      bit_d = 4'h0;
      byte_d = (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
    end else if (samp) begin
      bit_d = bit_q + 4'h1;
    end
  end

  // idle count resets saturated: the bus counts as free since reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      frame_q <= 1'b0;
      low_q <= 8'h00;
      free_q <= 8'hff;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      frame_q <= frame_d;
      low_q <= low_d;
      free_q <= free_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_drive_level_low: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
    else $error("open-drain output level not low");
  a_scl_low_width: assert property (rise |-> low_q == LOW_FAST[7:0] || low_q == LOW_STD[7:0])
    else $error("scl low time off");
  a_sensor_steady_high: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("sensor changed sda while scl high");
  a_read_bit_set: assert property (samp && byte_q == 3'h0 && bit_q == 4'h7 |-> sda)
    else $error("address byte without read bit");
  a_sensor_quiet_addr: assert property (samp && byte_q == 3'h0 && bit_q < 4'h8 |-> !s_sda_oe)
    else $error("sensor drove during address bits");
  a_master_ack_order: assert property (samp && bit_q == 4'h8 && (byte_q == 3'h1
    || byte_q == 3'h3) |-> !sda)
    else $error("master did not ack data byte");
  a_last_byte_nack: assert property (samp && bit_q == 4'h8 && byte_q == 3'h4 |-> sda)
    else $error("fourth byte not nacked");
  a_temp_pad_zero: assert property (samp && byte_q == 3'h4 && bit_q > 4'h2 && bit_q < 4'h8
    |-> !sda)
    else $error("pad bits of fourth byte not zero");
  a_data_ack_free: assert property (samp && byte_q != 3'h0 && bit_q == 4'h8 |-> !s_sda_oe)
    else $error("sensor drove a master ack slot");
  a_bus_free_gap: assert property (start_ev |-> free_q >= `T_BUF_CYC)
    else $error("start too soon after stop");

  c_full_read: cover property (samp && byte_q == 3'h4 && bit_q == 4'h8);
  c_short_read: cover property (samp && byte_q == 3'h2 && bit_q == 4'h8 && sda);
  c_addr_nack: cover property (samp && byte_q == 3'h0 && bit_q == 4'h8 && sda);
endmodule : readout_chk

`default_nettype wire

// File: sim/tb.sv
// testbench: host end reads sensor end over the shared link
// assumes both ends share one 20 MHz clock; results compared field by field
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"

module tb;
  import readout_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0, req_short = 1'b0, req_fast = 1'b0, res_ready = 1'b0;
  logic addr_load = 1'b0;
  logic [6:0] req_addr = 7'h00, addr_in = 7'h00;
  condition_code_e meas_cond = cond_normal;
  logic [13:0] meas_pressure = 14'h0000;
  logic [10:0] meas_temp = 11'h000;
  logic req_ready, res_valid, busy, snap_taken;
  logic [6:0] own_addr;
  readout_s res_data, r;
  int num_errors = 0;
  int tests_run = 0;
  logic [13:0] pv [4] = '{14'h0000, 14'h3fff, 14'h1fff, 14'h0666};
  logic [10:0] tv [4] = '{11'h000, 11'h7ff, 11'h400, 11'h2aa};
  logic [6:0] al [8] = '{`DEV_ADDR_ALT0, `DEV_ADDR_DEFAULT, `DEV_ADDR_ALT1, `DEV_ADDR_ALT2,
    `DEV_ADDR_ALT3, `DEV_ADDR_ALT4, `DEV_ADDR_ALT5, 7'h15};

  always #25 clk = ~clk;

  i2c_if i_i2c_if ();
  host_end i_host_end (.bus(i_i2c_if), .clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_short(req_short), .req_fast(req_fast),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  sensor_end i_sensor_end (.bus(i_i2c_if), .clk(clk), .rstn(rstn), .addr_load(addr_load),
    .addr_in(addr_in), .meas_cond(meas_cond), .meas_pressure(meas_pressure),
    .meas_temp(meas_temp), .own_addr(own_addr), .busy(busy), .snap_taken(snap_taken));
  readout_chk i_readout_chk (.clk(clk), .rstn(rstn), .m_scl_o(i_i2c_if.m_scl_o),
    .m_scl_oe(i_i2c_if.m_scl_oe), .m_sda_o(i_i2c_if.m_sda_o), .m_sda_oe(i_i2c_if.m_sda_oe),
    .s_sda_o(i_i2c_if.s_sda_o), .s_sda_oe(i_i2c_if.s_sda_oe), .scl(i_i2c_if.scl),
    .sda(i_i2c_if.sda));

  // all bench inputs move 2 ns after the rising edge
  task step;
    @(posedge clk);
    #2;
  endtask : step

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // request held until the edge that sees ready high
  task issue(input logic [6:0] a, input logic sh, input logic fs);
    int n;
    req_addr = a;
    req_short = sh;
    req_fast = fs;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 20000) begin
      step();
      n++;
    end
    if (n >= 20000) num_errors++; // host never became ready
    step();
    req_valid = 1'b0;
  endtask : issue

  task collect(output readout_s q);
    int n;
    n = 0;
    while (res_valid !== 1'b1 && n < 20000) begin
      step();
      n++;
    end
    if (n >= 20000) num_errors++; // no result arrived
    q = res_data;
    res_ready = 1'b1;
    step();
    res_ready = 1'b0;
  endtask : collect

  // one read; sensor inputs scrambled after the snapshot to prove it holds
  task rd(input logic [6:0] a, input logic sh, input logic fs, input condition_code_e c,
    input logic [13:0] p, input logic [10:0] t, input logic nk);
    int n, e_t, e_p;
    meas_cond = c;
    meas_pressure = p;
    meas_temp = t;
    e_t = int'(t) * `TEMP_MUL * `TEMP_FRAC / `TEMP_DIV - `TEMP_OFS * `TEMP_FRAC;
    e_p = ((int'(p) - 1638) * 2000) / 13107 - 1000;
    issue(a, sh, fs);
    n = 0;
    while (!nk && snap_taken !== 1'b1 && n < 9000) begin
      step();
      n++;
    end
    if (n >= 9000) num_errors++; // snapshot never latched
    check("busy", {31'h0, busy}, {31'h0, !nk});
    meas_pressure = ~p;
    meas_temp = ~t;
    meas_cond = condition_code_e'(~c);
    collect(r);
    step();
    check("busy_after", {31'h0, busy}, 32'h0000_0000);
    check("addr_nack", {31'h0, r.addr_nack}, {31'h0, nk});
    if (!nk) begin
      check("full_read", {31'h0, r.full_read}, {31'h0, !sh});
      check("condition", {30'h0, r.condition_code_field}, {30'h0, c});
      check("pressure", {18'h0, r.pressure_count_word}, {18'h0, p});
      check("pressure_scaled", r.pressure_scaled, e_p);
      check("temperature", {21'h0, r.temperature_count_word}, {21'h0, sh ? 11'h000 : t});
      if (!sh) check("temp_cx256", {14'h0, r.temp_cx256}, {14'h0, e_t[17:0]});
    end
  endtask : rd

  // hang guard: a full run needs well under half of this
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clk);
    #2;
    rstn = 1'b1;
    check("own_addr", {25'h0, own_addr}, {25'h0, `DEV_ADDR_DEFAULT});
    // every status code with boundary counts, fast full reads, then one standard full and one fast short read
    for (int i = 0; i < 4; i++) begin
      rd(`DEV_ADDR_DEFAULT, 1'b0, 1'b1, condition_code_e'(i), pv[i], tv[i], 1'b0);
    end
    rd(`DEV_ADDR_DEFAULT, 1'b0, 1'b0, cond_stale, 14'h2aaa, 11'h555, 1'b0);
    rd(`DEV_ADDR_DEFAULT, 1'b1, 1'b1, cond_diag, 14'h1555, 11'h0f0, 1'b0);
    // consumer stalls: two results queue and a third request is refused
    meas_pressure = 14'h0abc;
    issue(`DEV_ADDR_DEFAULT, 1'b1, 1'b1);
    step(); // let an edge pass so valid is not lowered and raised at once
    issue(`DEV_ADDR_DEFAULT, 1'b1, 1'b1);
    repeat (3000) step();
    check("req_ready_full", {31'h0, req_ready}, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      collect(r);
      step();
      check("queued_pressure", {18'h0, r.pressure_count_word}, 32'h0000_0abc);
    end
    check("req_ready_empty", {31'h0, req_ready}, 32'h0000_0001);
    // standard addresses and one custom value
    for (int i = 0; i < 8; i++) begin
      addr_in = al[i];
      addr_load = 1'b1;
      step();
      addr_load = 1'b0;
      check("own_addr", {25'h0, own_addr}, {25'h0, al[i]});
      rd(al[i], 1'b1, 1'b1, cond_normal, 14'h3001 + 14'(i), 11'h000, 1'b0);
    end
    rd(`DEV_ADDR_DEFAULT, 1'b1, 1'b1, cond_normal, 14'h0001, 11'h000, 1'b1);
    complete_run();
  end
endmodule : tb

`default_nettype wire

// File: src/host_end.sv
// host (master) end: reads the sensor and converts its counts
// assumes the sensor end on the same i2c_if and synchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"

module host_end #(
  parameter int P_MIN_CNT = 1638,
  parameter int P_MAX_CNT = 14745,
  parameter int P_MIN = -1000,
  parameter int P_MAX = 1000
) (
  i2c_if.host bus,
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [6:0] req_addr,
  input wire logic req_short,
  input wire logic req_fast,
  output logic res_valid,
  input wire logic res_ready,
  output readout_pkg::readout_s res_data
);
  import readout_pkg::*;

  typedef enum {h_idle, h_start, h_bit, h_stop, h_gap} hstate_e;

  hstate_e st_q, st_d;
  logic [6:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] slot_q, slot_d;
  logic [2:0] byt_q, byt_d;
  logic [6:0] addr_q, addr_d;
  logic short_q, short_d;
  logic fast_q, fast_d;
  logic nack_q, nack_d;
  logic scl_oe_q, scl_oe_d;
  logic sda_oe_q, sda_oe_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] rxb_q [4];
  logic [7:0] rxb_d [4];
  readout_s mem_q [2];
  readout_s mem_d [2];
  logic wp_q, wp_d;
  logic rp_q, rp_d;
  logic [1:0] fcnt_q, fcnt_d;
  logic [6:0] qtr;
  logic tick;
  logic [2:0] nbytes;
  logic [7:0] addr_byte;
  logic drive_low;
  logic push_c;
  logic pop_c;
  logic [13:0] pcnt;
  logic [10:0] tcnt;
  int tc_i;
  int pc_i;
  readout_s res_c;

  // quarter-bit pacing picks the bus rate of this read
  assign qtr = fast_q ? 7'(`QTR_FAST_CYC) : 7'(`QTR_STD_CYC);
  assign tick = (cnt_q == qtr - 7'd1);
  assign nbytes = short_q ? `BYTES_SHORT : `BYTES_FULL;
  assign addr_byte = {addr_q, 1'b1};

  // what the host puts on sda in the current slot
  always_comb begin
    if (byt_q == 3'd0) begin
      drive_low = (slot_q != 4'd8) && !addr_byte[3'(4'd7 - slot_q)];
    end else begin
      drive_low = (slot_q == 4'd8) && (byt_q != nbytes);
    end
  end

  // unpack the frame and convert counts
  always_comb begin
    pcnt = {rxb_q[0][5:0], rxb_q[1]} & `PRESS_MASK;
    tcnt = short_q ? 11'h000 : {rxb_q[2], rxb_q[3][7:5]};
    tc_i = $signed({21'd0, tcnt}) * `TEMP_MUL * `TEMP_FRAC / `TEMP_DIV
      - `TEMP_OFS * `TEMP_FRAC;
    pc_i = ($signed({18'd0, pcnt}) - P_MIN_CNT) * (P_MAX - P_MIN)
      / (P_MAX_CNT - P_MIN_CNT) + P_MIN;
    res_c.addr_nack = nack_q;
    res_c.full_read = !short_q;
    res_c.condition_code_field = condition_code_e'(2'(rxb_q[0] >> `STATUS_SHIFT));
    res_c.pressure_count_word = pcnt;
    res_c.temperature_count_word = tcnt;
    res_c.temp_cx256 = tc_i[17:0];
    res_c.pressure_scaled = pc_i;
  end

  // bus sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = tick ? 7'd0 : cnt_q + 7'd1;
    ph_d = tick ? ph_q + 2'd1 : ph_q;
    slot_d = slot_q;
    byt_d = byt_q;
    addr_d = addr_q;
    short_d = short_q;
    fast_d = fast_q;
    nack_d = nack_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    rx_d = rx_q;
    rxb_d = rxb_q;
    push_c = 1'b0;
    case (st_q)
      h_idle: begin
        cnt_d = 7'd0;
        ph_d = 2'd0;
        if (req_valid && req_ready) begin
          st_d = h_start;
          addr_d = req_addr;
          short_d = req_short;
          fast_d = req_fast;
          byt_d = 3'd0;
          slot_d = 4'd0;
          nack_d = 1'b0;
          rxb_d = '{default: 8'h00};
        end
      end
      h_start: begin
        if (tick && ph_q == 2'd1) sda_oe_d = 1'b1; // start: sda falls, scl high
        if (tick && ph_q == 2'd3) begin
          scl_oe_d = 1'b1;
          st_d = h_bit;
        end
      end
      h_bit: begin
        if (tick) begin
          case (ph_q)
            2'd0: sda_oe_d = drive_low; // data changes only while scl is low
            2'd1: scl_oe_d = 1'b0;
            2'd2: begin
              if (slot_q != 4'd8) rx_d = {rx_q[6:0], bus.sda};
              else if (byt_q == 3'd0) nack_d = bus.sda;
            end
            default: begin
              scl_oe_d = 1'b1;
              slot_d = (slot_q == 4'd8) ? 4'd0 : slot_q + 4'd1;
              if (slot_q == 4'd8) begin
                if (byt_q != 3'd0) rxb_d[2'(byt_q - 3'd1)] = rx_q;
                if ((byt_q == 3'd0 && nack_q) || byt_q == nbytes) st_d = h_stop;
                else byt_d = byt_q + 3'd1;
              end
            end
          endcase
        end
      end
      h_stop: begin
        if (tick) begin
          case (ph_q)
            2'd0: sda_oe_d = 1'b1;
            2'd1: scl_oe_d = 1'b0;
            2'd2: sda_oe_d = 1'b0; // stop: sda rises, scl high
            default: begin
              push_c = 1'b1;
              st_d = h_gap;
              cnt_d = 7'd0;
            end
          endcase
        end
      end
      h_gap: begin
        // bus free time before the next start
        cnt_d = cnt_q + 7'd1;
        ph_d = 2'd0;
        if (cnt_q == 7'(`T_BUF_CYC - 1)) st_d = h_idle;
      end
      default: st_d = h_idle;
    endcase
  end

  // two-entry result buffer; a new read only starts when a slot is free
  always_comb begin
    pop_c = res_valid && res_ready;
    mem_d = mem_q;
    if (push_c) mem_d[wp_q] = res_c;
    wp_d = wp_q ^ push_c;
    rp_d = rp_q ^ pop_c;
    fcnt_d = fcnt_q + {1'b0, push_c} - {1'b0, pop_c};
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= h_idle;
      cnt_q <= 7'd0;
      ph_q <= 2'd0;
      slot_q <= 4'd0;
      byt_q <= 3'd0;
      addr_q <= `DEV_ADDR_DEFAULT;
      short_q <= 1'b0;
      fast_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rx_q <= 8'h00;
      rxb_q <= '{default: 8'h00};
      mem_q <= '{default: '0};
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fcnt_q <= 2'd0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      slot_q <= slot_d;
      byt_q <= byt_d;
      addr_q <= addr_d;
      short_q <= short_d;
      fast_q <= fast_d;
      nack_q <= nack_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      rx_q <= rx_d;
      rxb_q <= rxb_d;
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      fcnt_q <= fcnt_d;
    end
  end

  assign req_ready = (st_q == h_idle) && (fcnt_q != 2'd2);
  assign res_valid = (fcnt_q != 2'd0);
  assign res_data = mem_q[rp_q];
  assign bus.m_scl_o = 1'b0; // open drain: only ever pulls low
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;
endmodule : host_end

`default_nettype wire

// File: src/i2c_if.sv
// two-wire open-drain link between host end and sensor end
// assumes pull-ups: a line is high unless some party enables its driver
`timescale 1ns/1ps
`default_nettype none

interface i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // wired-and of the open-drain drivers
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
    output m_sda_o, output m_sda_oe);
  modport device (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : i2c_if

`default_nettype wire

// File: src/readout_params.svh
// constants shared by both ends of the pressure/temperature readout link
// assumes a 20 MHz system clock on both ends
`ifndef READOUT_PARAMS_SVH
`define READOUT_PARAMS_SVH

// slave address: power-up value and the standard alternatives
`define DEV_ADDR_DEFAULT 7'h28
`define DEV_ADDR_ALT0 7'h08
`define DEV_ADDR_ALT1 7'h38
`define DEV_ADDR_ALT2 7'h48
`define DEV_ADDR_ALT3 7'h58
`define DEV_ADDR_ALT4 7'h68
`define DEV_ADDR_ALT5 7'h78

// frame layout
`define BYTES_FULL 3'h4
`define BYTES_SHORT 3'h2
`define BYTE_IDLE 8'hff
`define TEMP_PAD 5'h00
`define PRESS_MASK 14'h3fff
`define STATUS_SHIFT 6

// timing
`define CLK_KHZ 20000
`define CLK_PERIOD_NS 50
`define SCL_STD_KHZ 100
`define SCL_FAST_KHZ 400
`define QTR_STD_CYC ((`CLK_KHZ + 4 * `SCL_STD_KHZ - 1) / (4 * `SCL_STD_KHZ))
`define QTR_FAST_CYC ((`CLK_KHZ + 4 * `SCL_FAST_KHZ - 1) / (4 * `SCL_FAST_KHZ))
`define T_BUF_NS 2000
`define T_BUF_CYC ((`T_BUF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// temperature conversion, result in 1/256 degree
`define TEMP_DIV 2048
`define TEMP_MUL 200
`define TEMP_OFS 50
`define TEMP_FRAC 256

`endif

// File: src/readout_pkg.sv
// types shared by both ends of the readout link
// assumes readout_params.svh for all numeric constants
package readout_pkg;

  // 2-bit status code carried in the first byte
  typedef enum logic [1:0] {
    cond_normal = 2'h0,
    cond_command = 2'h1,
    cond_stale = 2'h2,
    cond_diag = 2'h3
  } condition_code_e;

  // one conversion result as the sensor holds it
  typedef struct packed {
    condition_code_e condition_code_field;
    logic [13:0] pressure_count_word;
    logic [10:0] temperature_count_word;
  } measure_s;

  // one finished read as the host hands it on
  typedef struct packed {
    logic addr_nack;
    logic full_read;
    condition_code_e condition_code_field;
    logic [13:0] pressure_count_word;
    logic [10:0] temperature_count_word;
    logic signed [17:0] temp_cx256;
    logic signed [31:0] pressure_scaled;
  } readout_s;

endpackage : readout_pkg

// File: src/sensor_end.sv
// sensor (slave) end: answers reads with status, pressure, temperature
// assumes scl/sda synchronous to clk and a host end on the same i2c_if
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"

module sensor_end (
  i2c_if.device bus,
  input wire logic clk,
  input wire logic rstn,
  input wire logic addr_load,
  input wire logic [6:0] addr_in,
  input wire readout_pkg::condition_code_e meas_cond,
  input wire logic [13:0] meas_pressure,
  input wire logic [10:0] meas_temp,
  output logic [6:0] own_addr,
  output logic busy,
  output logic snap_taken
);
  import readout_pkg::*;

  typedef enum {s_idle, s_addr, s_aack, s_send, s_mack} sstate_e;

  sstate_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [2:0] idx_q, idx_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic [6:0] addr_q, addr_d;
  measure_s snap_q, snap_d;
  logic taken_q, taken_d;
  logic scl_q;
  logic sda_q;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  // byte i of the frame built from the held snapshot
  function automatic logic [7:0] tx_byte(input logic [2:0] i, input measure_s m);
    case (i)
      3'd0: tx_byte = {m.condition_code_field, m.pressure_count_word[13:8]};
      3'd1: tx_byte = m.pressure_count_word[7:0];
      3'd2: tx_byte = m.temperature_count_word[10:3];
      3'd3: tx_byte = {m.temperature_count_word[2:0], `TEMP_PAD};
      default: tx_byte = `BYTE_IDLE; // reads past the frame see a released line
    endcase
  endfunction : tx_byte

  // line events; pins are already synchronous so one stage suffices
  assign start_c = scl_q && bus.scl && sda_q && !bus.sda;
  assign stop_c = scl_q && bus.scl && !sda_q && bus.sda;
  assign rise_c = !scl_q && bus.scl;
  assign fall_c = scl_q && !bus.scl;

  // protocol next state; start and stop override any state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    idx_d = idx_q;
    ack_d = ack_q;
    oe_d = oe_q;
    addr_d = addr_q;
    snap_d = snap_q;
    taken_d = 1'b0;

    if (addr_load) addr_d = addr_in;

    if (start_c) begin
      // repeated start restarts address phase as well
      st_d = s_addr;
      cnt_d = 4'd0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = s_idle;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        s_idle: begin
          oe_d = 1'b0;
        end

        s_addr: begin
          if (rise_c && cnt_q != 4'd8) begin
            sh_d = {sh_q[6:0], bus.sda};
            cnt_d = cnt_q + 4'd1;
          end else if (fall_c && cnt_q == 4'd8) begin
            // write requests are not acked: this end is read-only
            if (sh_q[7:1] == addr_q && sh_q[0]) begin
              st_d = s_aack;
              oe_d = 1'b1;
              snap_d = {meas_cond, meas_pressure, meas_temp};
              taken_d = 1'b1;
              idx_d = 3'd0;
            end else begin
              st_d = s_idle;
            end
          end
        end

        s_aack: begin
          // end of ack clock: put first data bit out while scl is low
          if (fall_c) begin
            tx_d = tx_byte(3'd0, snap_q);
            oe_d = !tx_d[7];
            cnt_d = 4'd0;
            st_d = s_send;
          end
        end

        s_send: begin
          if (fall_c) begin
            if (cnt_q == 4'd7) begin
              oe_d = 1'b0; // release for the master's ack bit
              st_d = s_mack;
            end else begin
              tx_d = {tx_q[6:0], 1'b1};
              oe_d = !tx_q[6];
              cnt_d = cnt_q + 4'd1;
            end
          end
        end

        s_mack: begin
          if (rise_c) begin
            ack_d = !bus.sda;
          end else if (fall_c) begin
            if (ack_q) begin
              idx_d = (idx_q == `BYTES_FULL) ? idx_q : idx_q + 3'd1;
              tx_d = tx_byte(idx_d, snap_q);
              oe_d = !tx_d[7];
              cnt_d = 4'd0;
              st_d = s_send;
            end else begin
              // nack ends the frame after any byte count
              st_d = s_idle;
            end
          end
        end

        default: begin
          st_d = s_idle;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= s_idle;
      cnt_q <= 4'd0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 3'd0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      addr_q <= `DEV_ADDR_DEFAULT;
      snap_q <= '0;
      taken_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      snap_q <= snap_d;
      taken_q <= taken_d;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // outputs; sda is open drain so only the enable carries data
  assign own_addr = addr_q;
  assign busy = (st_q != s_idle);
  assign snap_taken = taken_q;
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = oe_q;

endmodule : sensor_end

`default_nettype wire
